// ===== hw/mpd_pkg.sv
package mpd_pkg;
  // datapath widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int UWORD_W = 32;
  localparam int NREG = 32;

  // microinstruction formats, bits 31:30
  typedef enum logic [1:0] {
    MPD_FMT_RR = 2'h0,
    MPD_FMT_RI = 2'h1,
    MPD_FMT_BBIT = 2'h2,
    MPD_FMT_BFLD = 2'h3
  } mpd_fmt_t;

  // field positions
  localparam int F_DST = 25;
  localparam int F_ASRC = 20;
  localparam int F_BSRC = 15;
  localparam int F_FUNC_RR = 12;
  localparam int F_CIN_RR = 10;
  localparam int F_SHIFT = 7;
  localparam int F_SOUT_EN = 6;
  localparam int F_SIN_EN = 5;
  localparam int F_DEC = 4;
  localparam int F_LINK_UNC = 3;
  localparam int F_LINK_CNT = 2;
  localparam int F_FUNC_RI = 18;
  localparam int F_CIN_RI = 16;
  localparam int F_BIT = 21;
  localparam int F_SENSE = 20;
  localparam int F_INDEX = 19;

  // arithmetic/boolean function select
  localparam logic [2:0] FN_ADD = 3'h0;
  localparam logic [2:0] FN_AND = 3'h1;
  localparam logic [2:0] FN_OR = 3'h2;
  localparam logic [2:0] FN_XOR = 3'h3;

  // carry-in select
  localparam logic [1:0] CIN_ZERO = 2'h0;
  localparam logic [1:0] CIN_PREV = 2'h1;
  localparam logic [1:0] CIN_ONE = 2'h2;

  // shift operations
  localparam logic [2:0] SH_NONE = 3'h0;
  localparam logic [2:0] SH_L1 = 3'h1;
  localparam logic [2:0] SH_R1 = 3'h2;
  localparam logic [2:0] SH_L8 = 3'h3;
  localparam logic [2:0] SH_R8 = 3'h4;
  localparam logic [2:0] SH_ROT8 = 3'h5;
  localparam logic [2:0] SH_SEXT = 3'h6;
  localparam logic [2:0] SH_AVG = 3'h7;

  // field test select
  localparam logic [1:0] FLD_LO = 2'h0;
  localparam logic [1:0] FLD_HI = 2'h1;
  localparam logic [1:0] FLD_WORD = 2'h2;

  // dedicated register addresses and condition bits
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_COND = 5'h01;
  localparam logic [4:0] REG_LINK = 5'h02;
  localparam int COND_CARRY = 0;
  localparam int COND_OVF = 1;
  localparam int COND_SHIFT = 2;
  localparam int CNT_LSB = 8;

  // bus register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_COND = 8'h08;
  localparam logic [7:0] OFS_DBG_SEL = 8'h0c;
  localparam logic [7:0] OFS_DBG_DATA = 8'h10;

  // reset values
  localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // timing: one microinstruction per clock
  localparam int CYCLE_MAX_NS = 90;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYCLES_PER_UINSTR = (CYCLE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : mpd_pkg

// ===== hw/mpd_core.sv
// Function
// - thirty-two addressable sixteen-bit data registers
// - registers four to thirty-one may be absent
// - control-store constant replaces register operand
// - operand buses feed unit, shifter drives result
// - sixteen-bit adder reports carry and overflow
// - boolean unit does AND, OR, XOR
// - shifter transforms arithmetic or boolean result
// - taken branch targets microword or register two
// - test single bit, byte or word
// - counter decrements and tests in same step
// - whole microinstruction completes in one cycle
// - register zero reads zero, ignores writes
// - unconnected register reads zero on first bus
// - carry-in zero, previous carry, or one
// - register one holds conditions and counter
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module mpd_core #(
  parameter logic [31:0] POPULATED = 32'hffff_ffff,
  parameter logic [31:0] A_CONNECTED = 32'h0000_00ff
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [mpd_pkg::ADDR_W-1:0] rom_addr,
  input wire logic [mpd_pkg::UWORD_W-1:0] rom_data,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic running
);
  localparam int DW = mpd_pkg::DATA_W;
  localparam int AW = mpd_pkg::ADDR_W;

  // state
  logic [AW-1:0] pc;
  logic [DW-1:0] regs [mpd_pkg::NREG];
  logic [DW-1:0] next_regs [mpd_pkg::NREG];
  logic [AW-1:0] next_pc;

  // bus-side control state
  logic run;
  logic next_run;
  logic [4:0] dbg_sel;
  logic [4:0] next_dbg_sel;

  // data phase bookkeeping
  logic [31:0] next_hrdata;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;

  // decoded microword
  logic [31:0] uw;
  mpd_pkg::mpd_fmt_t fmt;
  logic [4:0] dst;
  logic [4:0] a_src;
  logic [4:0] b_src;
  logic [2:0] func;
  logic [1:0] cin_sel;
  logic [2:0] shop;

  // operand, unit and result buses
  logic [DW-1:0] a_bus;
  logic [DW-1:0] b_bus;
  logic [DW-1:0] d_bus;
  logic [DW-1:0] ab_res;

  // adder and shifter flags
  logic [DW:0] sum;
  logic cin;
  logic carry_out;
  logic ovf;
  logic sh_out;
  logic sh_in;

  // sequencing and branch test
  logic is_alu;
  logic [7:0] cnt_dec;
  logic take_branch;
  logic [DW-1:0] test_val;
  logic [AW-1:0] br_target;

  // source read: absent slots and register zero read zero
  function automatic logic [DW-1:0] src_read(input logic [4:0] idx, input logic a_side,
                                             input logic [DW-1:0] rf [mpd_pkg::NREG]);
    logic [DW-1:0] v;
    v = rf[idx];
    if (idx == mpd_pkg::REG_ZERO || !POPULATED[idx]) begin
      v = '0;
    end
    if (a_side && !A_CONNECTED[idx]) begin
      v = '0;
    end
    return v;
  endfunction : src_read

  // field test: a zero field takes the branch when sense is set
  function automatic logic sense_hit(input logic is_zero, input logic sense);
    return is_zero == sense;
  endfunction : sense_hit

  // read-back word for a bus offset; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] ofs, input logic run_bit,
                                            input logic [AW-1:0] pc_val, input logic [4:0] sel,
                                            input logic [DW-1:0] rf [mpd_pkg::NREG]);
    logic [31:0] v;
    unique case (ofs)
      mpd_pkg::OFS_CTRL: v = {31'h0000_0000, run_bit};
      mpd_pkg::OFS_PC: v = {20'h00000, pc_val};
      mpd_pkg::OFS_COND: v = {16'h0000, rf[mpd_pkg::REG_COND]};
      mpd_pkg::OFS_DBG_SEL: v = {27'h0000000, sel};
      mpd_pkg::OFS_DBG_DATA: v = {16'h0000, rf[sel]};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_word

  assign uw = rom_data;
  assign fmt = mpd_pkg::mpd_fmt_t'(uw[31:30]);
  assign dst = uw[mpd_pkg::F_DST +: 5];
  assign a_src = uw[mpd_pkg::F_ASRC +: 5];
  assign b_src = uw[mpd_pkg::F_BSRC +: 5];
  assign is_alu = (fmt == mpd_pkg::MPD_FMT_RR) || (fmt == mpd_pkg::MPD_FMT_RI);

  // sequence address and run status
  assign rom_addr = pc;
  assign running = run;

  // zero wait states, always an okay response
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // operand buses; immediate format takes its constant on the second bus
  always_comb begin
    a_bus = src_read(a_src, 1'b1, regs);
    if (fmt == mpd_pkg::MPD_FMT_RI) begin
      b_bus = uw[DW-1:0];
      func = {1'b0, uw[mpd_pkg::F_FUNC_RI +: 2]};
      cin_sel = uw[mpd_pkg::F_CIN_RI +: 2];
      shop = mpd_pkg::SH_NONE;
    end else begin
      b_bus = src_read(b_src, 1'b0, regs);
      func = uw[mpd_pkg::F_FUNC_RR +: 3];
      cin_sel = uw[mpd_pkg::F_CIN_RR +: 2];
      shop = uw[mpd_pkg::F_SHIFT +: 3];
    end
  end

  // arithmetic/boolean unit
  always_comb begin
    unique case (cin_sel)
      mpd_pkg::CIN_PREV: cin = regs[mpd_pkg::REG_COND][mpd_pkg::COND_CARRY];
      mpd_pkg::CIN_ONE: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, a_bus} + {1'b0, b_bus} + {{DW{1'b0}}, cin};
    carry_out = sum[DW];
    ovf = (a_bus[DW-1] == b_bus[DW-1]) && (sum[DW-1] != a_bus[DW-1]);
    unique case (func)
      mpd_pkg::FN_AND: ab_res = a_bus & b_bus;
      mpd_pkg::FN_OR: ab_res = a_bus | b_bus;
      mpd_pkg::FN_XOR: ab_res = a_bus ^ b_bus;
      default: ab_res = sum[DW-1:0];
    endcase
  end

  // shifter on the unit output
  always_comb begin
    sh_in = uw[mpd_pkg::F_SIN_EN] & regs[mpd_pkg::REG_COND][mpd_pkg::COND_SHIFT];
    sh_out = 1'b0;
    d_bus = ab_res;
    unique case (shop)
      mpd_pkg::SH_L1: begin
        d_bus = {ab_res[DW-2:0], sh_in};
        sh_out = ab_res[DW-1];
      end
      mpd_pkg::SH_R1: begin
        d_bus = {sh_in, ab_res[DW-1:1]};
        sh_out = ab_res[0];
      end
      mpd_pkg::SH_L8: begin
        d_bus = {ab_res[7:0], 8'h00};
        sh_out = ab_res[8];
      end
      mpd_pkg::SH_R8: begin
        d_bus = {8'h00, ab_res[15:8]};
        sh_out = ab_res[7];
      end
      mpd_pkg::SH_ROT8: d_bus = {ab_res[7:0], ab_res[15:8]};
      mpd_pkg::SH_SEXT: d_bus = {ab_res[15:8], {8{ab_res[8]}}};
      mpd_pkg::SH_AVG: begin
        d_bus = {carry_out, ab_res[DW-1:1]};
        sh_out = ab_res[0];
      end
      default: d_bus = ab_res;
    endcase
  end

  // branch unit: bit, field or counter tests
  always_comb begin
    test_val = src_read(dst, 1'b0, regs);
    cnt_dec = regs[mpd_pkg::REG_COND][15:8] - 8'h01;
    br_target = uw[AW-1:0];
    if (uw[mpd_pkg::F_INDEX]) begin
      br_target = uw[AW-1:0] + regs[mpd_pkg::REG_LINK][AW-1:0];
    end
    take_branch = 1'b0;
    unique case (fmt)
      mpd_pkg::MPD_FMT_BBIT: begin
        take_branch = test_val[uw[mpd_pkg::F_BIT +: 4]] == uw[mpd_pkg::F_SENSE];
      end
      mpd_pkg::MPD_FMT_BFLD: begin
        unique case (uw[mpd_pkg::F_BIT +: 2])
          mpd_pkg::FLD_LO: take_branch = sense_hit(test_val[7:0] == 8'h00, uw[mpd_pkg::F_SENSE]);
          mpd_pkg::FLD_HI: take_branch = sense_hit(test_val[15:8] == 8'h00, uw[mpd_pkg::F_SENSE]);
          default: take_branch = sense_hit(test_val == 16'h0000, uw[mpd_pkg::F_SENSE]);
        endcase
      end
      // register format: link branch, unconditional or while counter not zero
      mpd_pkg::MPD_FMT_RR: begin
        br_target = regs[mpd_pkg::REG_LINK][AW-1:0];
        take_branch = uw[mpd_pkg::F_LINK_UNC] ||
                      (uw[mpd_pkg::F_LINK_CNT] && uw[mpd_pkg::F_DEC] && cnt_dec != 8'h00);
      end
      mpd_pkg::MPD_FMT_RI: take_branch = 1'b0;
    endcase
  end

  // next sequence address and register file
  always_comb begin
    next_pc = pc;
    for (int i = 0; i < mpd_pkg::NREG; i++) begin
      next_regs[i] = regs[i];
    end
    if (run) begin
      next_pc = take_branch ? br_target : pc + 12'h001;
      // destination write from the result bus
      if (is_alu && dst != mpd_pkg::REG_ZERO && POPULATED[dst]) begin
        next_regs[dst] = d_bus;
      end
      // condition/counter register: conditions never come from the result bus
      next_regs[mpd_pkg::REG_COND][7:0] = 8'h00;
      next_regs[mpd_pkg::REG_COND][2:0] = regs[mpd_pkg::REG_COND][2:0];
      // counter decrement; a load from the result bus wins
      if (is_alu && fmt == mpd_pkg::MPD_FMT_RR && uw[mpd_pkg::F_DEC]) begin
        next_regs[mpd_pkg::REG_COND][15:8] = cnt_dec;
      end
      if (is_alu && dst == mpd_pkg::REG_COND) begin
        next_regs[mpd_pkg::REG_COND][15:8] = d_bus[15:8];
      end
      if (is_alu && func == mpd_pkg::FN_ADD) begin
        next_regs[mpd_pkg::REG_COND][mpd_pkg::COND_CARRY] = carry_out;
        next_regs[mpd_pkg::REG_COND][mpd_pkg::COND_OVF] = ovf;
      end
      if (fmt == mpd_pkg::MPD_FMT_RR && uw[mpd_pkg::F_SOUT_EN] && shop != mpd_pkg::SH_NONE) begin
        next_regs[mpd_pkg::REG_COND][mpd_pkg::COND_SHIFT] = sh_out;
      end
    end
    // register zero never holds anything
    next_regs[mpd_pkg::REG_ZERO] = mpd_pkg::REG_RESET;
  end

  // single common edge for every piece of machine state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pc <= mpd_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // register slots; absent slots stay at zero
  genvar g;
  generate
    for (g = 0; g < mpd_pkg::NREG; g++) begin : g_reg
      if (POPULATED[g] && g != 0) begin : g_pop
        always_ff @(posedge core_clk or posedge reset) begin
          if (reset) begin
            regs[g] <= mpd_pkg::REG_RESET;
          end else begin
            regs[g] <= next_regs[g];
          end
        end
      end else begin : g_abs
        assign regs[g] = mpd_pkg::REG_RESET;
      end
    end
  endgenerate

  // ahb-lite slave: zero wait states, writes land in the data phase
  always_comb begin
    next_run = run;
    next_dbg_sel = dbg_sel;
    next_hrdata = hrdata;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    // data phase of a write: apply the held address
    if (wr_pend) begin
      unique case (wr_addr)
        mpd_pkg::OFS_CTRL: next_run = hwdata[0];
        mpd_pkg::OFS_DBG_SEL: next_dbg_sel = hwdata[4:0];
        default: next_run = run;
      endcase
    end
    // address phase: latch the request, read data stands next cycle
    if (hsel && hready && htrans[1]) begin
      next_wr_pend = hwrite;
      next_wr_addr = haddr[7:0];
      next_hrdata = 32'h0000_0000;
      if (!hwrite) begin
        next_hrdata = read_word(haddr[7:0], run, pc, dbg_sel, regs);
      end
    end
  end

  // bus-side registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run <= 1'b0;
      dbg_sel <= 5'h00;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      run <= next_run;
      dbg_sel <= next_dbg_sel;
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end
endmodule : mpd_core

// ===== testbench/mpd_core_properties.sv
`timescale 1ns/1ps
module mpd_core_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [mpd_pkg::ADDR_W-1:0] rom_addr,
  input wire logic [mpd_pkg::UWORD_W-1:0] rom_data,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic running
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // decoded bus request, microword fields and next sequential address
  wire take = hsel & hready & htrans[1];
  wire [1:0] fmt = rom_data[31:30];
  wire sense = rom_data[20];
  wire [11:0] target = rom_data[11:0];
  wire [11:0] step = rom_addr + 12'h001;
  wire reg0 = rom_data[29:25] == 5'h00 && !rom_data[19];

  a_idle_hold: assert property (!running |=> $stable(rom_addr))
    else $error("address moved while halted");
  a_seq_step: assert property (running && fmt == 2'h0 && !rom_data[3] && !rom_data[2] |=> rom_addr == $past(step))
    else $error("no sequential step");
  a_imm_step: assert property (running && fmt == 2'h1 |=> rom_addr == $past(step))
    else $error("immediate word did not step");
  a_bit_test: assert property (running && fmt == 2'h2 && reg0 |=>
    rom_addr == ($past(sense) ? $past(step) : $past(target)))
    else $error("bit test wrong");
  a_field_test: assert property (running && fmt == 2'h3 && reg0 && rom_data[22:21] == 2'h2 |=>
    rom_addr == ($past(sense) ? $past(target) : $past(step)))
    else $error("field test wrong");
  a_pc_read: assert property (take && !hwrite && haddr[7:0] == mpd_pkg::OFS_PC |=>
    hrdata == {20'h0, $past(rom_addr)})
    else $error("address read wrong");
  a_run_write: assert property (take && hwrite && haddr[7:0] == mpd_pkg::OFS_CTRL ##1 1'b1 |=>
    running == $past(hwdata[0]))
    else $error("run bit not written");
  a_cond_fixed: assert property (take && !hwrite && haddr[7:0] == mpd_pkg::OFS_COND |=>
    hrdata[31:16] == 16'h0000 && hrdata[7:3] == 5'h00)
    else $error("condition zero bits set");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_reset_clear: assert property ($fell(reset) |-> rom_addr == 12'h000 && !running)
    else $error("reset state wrong");
  // main scenarios
  c_bit: cover property (running && fmt == 2'h2);
  c_field: cover property (running && fmt == 2'h3);
  c_write: cover property (take && hwrite);
endmodule : mpd_core_properties

// ===== testbench/mpd_rom.sv
`timescale 1ns/1ps
module mpd_rom (
  input wire logic [mpd_pkg::ADDR_W-1:0] rom_addr,
  output logic [mpd_pkg::UWORD_W-1:0] rom_data
);
  logic [31:0] mem [4096];
  // every word parks on a self-loop until loaded
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = {2'h2, 18'h0, 12'(i)};
  end
  // combinational fetch, valid in the same cycle
  assign rom_data = mem[rom_addr];
endmodule : mpd_rom

// ===== testbench/mpd_core_tb_top.sv
`timescale 1ns/1ps
module mpd_core_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rnd = 32'h013862e2;
  logic [31:0] hrdata, rd, w;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] rom_addr;
  logic [31:0] rom_data;
  logic hreadyout, hresp, running;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int r [32];
  int c, ov, n, k, a, b, s, f, ci, d;
  int t, so, si, shf, cs;
  // clock
  always #50 core_clk = ~core_clk;
  mpd_core mpd_core_i (.core_clk(core_clk), .reset(reset), .rom_addr(rom_addr), .rom_data(rom_data),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .running(running));
  mpd_rom mpd_rom_i (.rom_addr(rom_addr), .rom_data(rom_data));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask : bus
  // reference execution of one register or immediate microword
  task automatic exec(input logic [31:0] x);
    a = (x[24:20] < 8) ? r[x[24:20]] : 0;
    b = x[30] ? int'(x[15:0]) : r[x[19:15]];
    f = x[30] ? x[19:18] : x[14:12];
    ci = x[30] ? x[17:16] : x[11:10];
    ci = (ci == 1) ? c : (ci == 2);
    cs = (a + b + ci) >> 16;
    si = (!x[30] && x[5]) ? shf : 0;
    if (f == 0) begin
      s = a + b + ci;
      ov = (a[15] == b[15]) && (s[15] != a[15]);
      c = s[16];
    end
    else s = (f == 1) ? a & b : (f == 2) ? a | b : a ^ b;
    t = s & 16'hffff;
    so = 0;
    case (x[30] ? 3'h0 : x[9:7])
      1: begin so = t[15]; t = ((t << 1) & 16'hffff) | si; end
      2: begin so = t[0]; t = (t >> 1) | (si << 15); end
      3: begin so = t[8]; t = (t << 8) & 16'hffff; end
      4: begin so = t[7]; t = t >> 8; end
      5: t = ((t << 8) | (t >> 8)) & 16'hffff;
      6: t = (t & 16'hff00) | (t[8] ? 16'hff : 0);
      7: begin so = t[0]; t = (t >> 1) | (cs << 15); end
      default: t = t;
    endcase
    if (!x[30] && x[6] && x[9:7] != 0) shf = so;
    if (x[29:25] != 0) r[x[29:25]] = t;
    r[1] = shf * 4 + ov * 2 + c;
  endtask : exec
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      finish_test();
    end
  end
  // main sequence: two rounds, each behind its own reset
  initial begin
    for (k = 0; k < 2; k++) begin
      reset <= 1'b1;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      r = '{default: 0};
      c = 0;
      ov = 0;
      shf = 0;
      for (n = 0; n < 24; n++) begin
        rnd = lfsr(rnd);
        d = (rnd[2:0] == 3'h0) ? 0 : rnd[2:0] + 2;
        a = rnd[12:9] % 10;
        b = rnd[16:13] % 10;
        if (n < 6) w = {2'h1, 5'(n + 3), 5'h0, 2'h2, 2'h0, rnd[31:16]};
        else if (rnd[8]) w = {2'h1, 5'(d), 5'(a), rnd[18:17], 2'(rnd[20:19] % 3), rnd[31:16]};
        else w = {2'h0, 5'(d), 5'(a), 5'(b), 1'b0, rnd[18:17], 2'(rnd[20:19] % 3), rnd[25:23], rnd[26], rnd[27], 5'h0};
        mpd_rom_i.mem[n] = w;
        exec(w);
      end
      mpd_rom_i.mem[24] = {2'h2, 5'h0, 4'h0, 1'b1, 1'b0, 7'h0, 12'h000};
      mpd_rom_i.mem[25] = {2'h3, 5'h0, 2'h0, 2'h2, 1'b0, 1'b0, 7'h0, 12'h000};
      mpd_rom_i.mem[26] = {2'h2, 5'h0, 4'h0, 1'b0, 1'b0, 7'h0, 12'd26};
      bus(1'b1, mpd_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge core_clk);
      bus(1'b1, mpd_pkg::OFS_CTRL, 32'h0);
      bus(1'b1, mpd_pkg::OFS_PC, 32'h5);
      bus(1'b0, mpd_pkg::OFS_PC, 32'h0);
      chk(rd, 32'd26);
      bus(1'b0, mpd_pkg::OFS_COND, 32'h0);
      chk(rd, 32'(r[1]));
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      for (n = 0; n < 32; n++) begin
        bus(1'b1, mpd_pkg::OFS_DBG_SEL, 32'(n));
        bus(1'b0, mpd_pkg::OFS_DBG_DATA, 32'h0);
        chk(rd, 32'(r[n]));
      end
      $display("round %0d done", k);
    end
    finish_test();
  end
endmodule : mpd_core_tb_top
bind mpd_core mpd_core_properties mpd_core_properties_i (.core_clk(core_clk), .reset(reset),
  .rom_addr(rom_addr), .rom_data(rom_data), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .running(running));
